// File: inc/ssp_link_if.sv
`timescale 1ns/1ps
interface ssp_link_if;
  logic sck; // Shift clock, driven by the master end
  logic dev_dt_out; // Data from the device end
  logic dev_dt_oe; // Device drives data
  logic host_dt_out; // Data from the master end
  logic host_dt_oe; // Master drives data
  logic dt; // Resolved data line, pulled high when idle

  assign dt = dev_dt_oe ? dev_dt_out : (host_dt_oe ? host_dt_out : 1'b1);

  modport device(input sck, input dt, output dev_dt_out, output dev_dt_oe);
  modport host(output sck, input dt, output host_dt_out, output host_dt_oe);
endinterface

// File: inc/ssp_pkg.sv
package ssp_pkg;

  // ----------------------------------------------------------------
  // Device register byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_TX_CTRL = 5'h00; // transmit_status_control
  localparam logic [4:0] REG_TX_HOLD = 5'h04; // transmit_holding
  localparam logic [4:0] REG_RX_CTRL = 5'h08; // receive_status_control
  localparam logic [4:0] REG_RX_BUF = 5'h0c; // receive_buffer
  localparam logic [4:0] REG_BAUD = 5'h10; // baud_control
  localparam logic [4:0] REG_IRQ = 5'h14; // irq enables and flags

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TX_CLOCK_ORIGIN_SELECT = 7; // clock_origin_select
  localparam int TX_NINE = 6; // nine_bit_transmit_select
  localparam int TX_EN = 5; // transmit_enable
  localparam int TX_SYNC = 4; // synchronous mode
  localparam int TX_TRMT = 1; // shifter empty
  localparam int TX_D9 = 0; // transmit_ninth_bit
  localparam int RX_PORT_ENABLE = 7; // port_enable
  localparam int RX_NINE = 6; // nine_bit_receive_select
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5; // single_receive_enable
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4; // continuous_receive_enable
  localparam int RX_OERR = 1; // overrun error
  localparam int RX_D9 = 0; // receive_ninth_bit
  localparam int IRQ_TRANSMIT_IRQ_ENABLE = 0; // transmit_irq_enable
  localparam int IRQ_RECEIVE_IRQ_ENABLE = 1; // receive_irq_enable
  localparam int IRQ_TRANSMIT_EMPTY_FLAG = 4; // transmit_empty_flag
  localparam int IRQ_RECEIVE_COMPLETE_FLAG = 5; // receive_complete_flag

  // ----------------------------------------------------------------
  // Reset values and word lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [3:0] LEN9 = 4'h9;

  // ----------------------------------------------------------------
  // Master end: registers, fields, clock divider
  // ----------------------------------------------------------------
  localparam logic [4:0] HREG_CTRL = 5'h00;
  localparam logic [4:0] HREG_TXD = 5'h04;
  localparam logic [4:0] HREG_RXD = 5'h08;
  localparam int H_GO = 0;
  localparam int H_NINE = 1;
  localparam int H_DRIVE = 2;
  localparam int H_BUSY = 3;
  localparam int H_DONE = 4;
  localparam logic [3:0] HOST_HALF = 4'h8; // Cycles per clock half

endpackage

// File: logic/ssp_device.sv
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Function
// - Clock origin cleared selects external shift clock
// - Shifting continues while core sleeps
// - Slave transmit equals master transmit
// - First word moves to shifter immediately
// - Empty flag stays clear while holding full
// - Move held word, then set empty flag
// - Empty flag raises enabled transmit interrupt
// - Software configures slave transmit mode bits
// - Software loads ninth bit before data
// - Single receive enable ignored in slave
// - Continuous receive works in low power
// - Completed word moves to receive buffer
// - Receive flag set; interrupt only if enabled
// - Software reads status before data
// - Clearing continuous receive clears errors
// - Nine bit receive captures ninth bit
// - Software sets global and peripheral enables
// - Receive data sampled at clock falling edge
// - Continuous receive repeats until cleared
module ssp_device
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ssp_link_if.device link,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic tx_irq,
  output logic rx_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] sck_sync; // Shift clock synchroniser
  logic [1:0] dt_sync; // Data line synchroniser
  logic sck_prev; // Last synchronised clock level
  logic ack; // Bus answer cycle
  logic clock_origin_select; // High selects internal clock
  logic nine_bit_transmit_select;
  logic transmit_enable;
  logic sync_mode;
  logic transmit_ninth_bit;
  logic port_enable;
  logic nine_bit_receive_select;
  logic single_receive_enable; // Stored only
  logic continuous_receive_enable;
  logic [7:0] baud_control; // Stored only
  logic transmit_irq_enable;
  logic receive_irq_enable;
  logic [7:0] transmit_holding; // Waiting word
  logic hold_full; // Holding register occupied
  logic [8:0] transmit_shifter; // Outgoing bits
  logic tx_busy; // Word being shifted
  logic tx_first; // First rising edge not yet seen
  logic [3:0] tx_cnt; // Bits sampled so far
  logic [8:0] receive_shifter; // Incoming bits
  logic [3:0] rx_cnt; // Bits received so far
  logic [7:0] receive_buffer; // Completed word
  logic receive_ninth_bit;
  logic buf_full; // Receive complete flag
  logic overrun; // Overrun error

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire sck_rise = sck_sync[1] & ~sck_prev; // Detected rising edge
  wire sck_fall = ~sck_sync[1] & sck_prev; // Detected falling edge
  wire access = (read | write) & ~ack; // Request waiting for answer
  wire wr_done = write & ack; // Write takes effect
  wire rd_done = read & ack; // Read completes
  wire sel_tx_ctrl = (address == REG_TX_CTRL);
  wire sel_tx_hold = (address == REG_TX_HOLD);
  wire sel_rx_ctrl = (address == REG_RX_CTRL);
  wire sel_rx_buf = (address == REG_RX_BUF);
  wire sel_baud = (address == REG_BAUD);
  wire sel_irq = (address == REG_IRQ);
  // Slave link is live only with external clock selected
  wire link_on = port_enable & sync_mode & ~clock_origin_select;
  wire tx_on = link_on & transmit_enable;
  // Single receive enable plays no part here
  wire rx_on = link_on & continuous_receive_enable;
  wire [3:0] tx_len = nine_bit_transmit_select ? LEN9 : LEN8;
  wire [3:0] rx_len = nine_bit_receive_select ? LEN9 : LEN8;
  wire tx_last = tx_busy & sck_fall & (tx_cnt == tx_len - 4'h1);
  // Next word enters the shifter when idle or as the last bit ends
  wire tx_load = tx_on & hold_full & (~tx_busy | tx_last);
  wire hold_wr = wr_done & sel_tx_hold;
  // A write is taken when holding is free or emptying this cycle
  wire hold_take = hold_wr & (~hold_full | tx_load);
  wire [8:0] rx_next = {dt_sync[1], receive_shifter[8:1]};
  wire rx_done = rx_on & sck_fall & (rx_cnt == rx_len - 4'h1);
  wire buf_read = rd_done & sel_rx_buf;
  wire buf_free = ~buf_full | buf_read;
  wire [7:0] rx_word = nine_bit_receive_select ? rx_next[7:0] : rx_next[8:1];
  wire rx_word9 = nine_bit_receive_select & rx_next[8];
  wire transmit_empty_flag = ~hold_full;
  wire [7:0] tx_ctrl_rd = {clock_origin_select, nine_bit_transmit_select,
                           transmit_enable, sync_mode, 2'b00, ~tx_busy,
                           transmit_ninth_bit};
  wire [7:0] rx_ctrl_rd = {port_enable, nine_bit_receive_select,
                           single_receive_enable, continuous_receive_enable,
                           2'b00, overrun, receive_ninth_bit};
  wire [7:0] irq_rd = {2'b00, buf_full, transmit_empty_flag, 2'b00,
                       receive_irq_enable, transmit_irq_enable};
  wire [7:0] rd_val = sel_tx_ctrl ? tx_ctrl_rd :
                      sel_rx_ctrl ? rx_ctrl_rd :
                      sel_rx_buf ? receive_buffer :
                      sel_baud ? baud_control :
                      sel_irq ? irq_rd : 8'h00;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waitrequest = access;
  // Device drives the line only in transmit, not while receiving
  assign link.dev_dt_oe = tx_on & ~continuous_receive_enable;
  assign link.dev_dt_out = transmit_shifter[0];
  assign tx_irq = transmit_irq_enable & transmit_empty_flag;
  assign rx_irq = receive_irq_enable & buf_full;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  // Clock and data pins pass two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_sync <= 2'h0;
      dt_sync <= 2'h3;
      sck_prev <= 1'b0;
    end else if (ce) begin
      sck_sync <= {sck_sync[0], link.sck};
      dt_sync <= {dt_sync[0], link.dt};
      sck_prev <= sck_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait state, registered read data
  // ----------------------------------------------------------------
  // Answer follows one cycle after the request appears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      readdata <= 32'h0;
    end else if (ce) begin
      ack <= access;
      if (access && read) begin
        readdata <= {24'h0, rd_val};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Software setup writes; reset leaves the port disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {clock_origin_select, nine_bit_transmit_select} <= 2'b00;
      {transmit_enable, sync_mode, transmit_ninth_bit} <= 3'b000;
      {port_enable, nine_bit_receive_select} <= 2'b00;
      {single_receive_enable, continuous_receive_enable} <= 2'b00;
      {receive_irq_enable, transmit_irq_enable} <= 2'b00;
      baud_control <= CTRL_RST;
    end else if (ce && wr_done) begin
      if (sel_tx_ctrl) begin
        clock_origin_select <= writedata[TX_CLOCK_ORIGIN_SELECT];
        nine_bit_transmit_select <= writedata[TX_NINE];
        transmit_enable <= writedata[TX_EN];
        sync_mode <= writedata[TX_SYNC];
        transmit_ninth_bit <= writedata[TX_D9];
      end
      if (sel_rx_ctrl) begin
        port_enable <= writedata[RX_PORT_ENABLE];
        nine_bit_receive_select <= writedata[RX_NINE];
        single_receive_enable <= writedata[RX_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable <= writedata[RX_CONTINUOUS_RECEIVE_ENABLE];
      end
      if (sel_baud) begin
        baud_control <= writedata[7:0];
      end
      if (sel_irq) begin
        transmit_irq_enable <= writedata[IRQ_TRANSMIT_IRQ_ENABLE];
        receive_irq_enable <= writedata[IRQ_RECEIVE_IRQ_ENABLE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit holding register
  // ----------------------------------------------------------------
  // Holds the second word while the first shifts out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_holding <= 8'h00;
      hold_full <= 1'b0;
    end else if (ce) begin
      if (hold_take) begin
        // New word refills, even as the old one leaves
        transmit_holding <= writedata[7:0];
        hold_full <= 1'b1;
      end else if (tx_load) begin
        // Held word moved on; empty flag rises now
        hold_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter, clocked only by the external edges
  // ----------------------------------------------------------------
  // Bit 0 stands on load, changes after each later rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_shifter <= 9'h1ff;
      tx_busy <= 1'b0;
      tx_first <= 1'b0;
      tx_cnt <= 4'h0;
    end else if (ce) begin
      if (!tx_on) begin
        // Transmit disabled: abandon any word in flight
        tx_busy <= 1'b0;
        tx_cnt <= 4'h0;
      end else if (tx_load) begin
        // Ninth bit follows the eighth
        transmit_shifter <= {transmit_ninth_bit, transmit_holding};
        tx_busy <= 1'b1;
        tx_first <= 1'b1;
        tx_cnt <= 4'h0;
      end else if (tx_last) begin
        // Word complete with nothing waiting
        tx_busy <= 1'b0;
        tx_cnt <= 4'h0;
      end else if (tx_busy) begin
        // Same pattern as master transmit, external edges only
        if (sck_rise && tx_first) begin
          tx_first <= 1'b0;
        end else if (sck_rise) begin
          transmit_shifter <= {1'b1, transmit_shifter[8:1]};
        end
        if (sck_fall) begin
          tx_cnt <= tx_cnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  // Samples the line at each falling edge, word after word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_shifter <= 9'h000;
      rx_cnt <= 4'h0;
    end else if (ce) begin
      if (!rx_on) begin
        rx_cnt <= 4'h0;
      end else if (rx_done) begin
        // Restart counting for the next word
        receive_shifter <= rx_next;
        rx_cnt <= 4'h0;
      end else if (sck_fall) begin
        receive_shifter <= rx_next;
        rx_cnt <= rx_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer, complete flag and overrun
  // ----------------------------------------------------------------
  // A completed word wins over a read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_buffer <= 8'h00;
      receive_ninth_bit <= 1'b0;
      buf_full <= 1'b0;
      overrun <= 1'b0;
    end else if (ce) begin
      if (rx_done && buf_free) begin
        receive_buffer <= rx_word;
        receive_ninth_bit <= rx_word9;
        buf_full <= 1'b1;
      end else if (buf_read) begin
        // Reading the data word clears the flag
        buf_full <= 1'b0;
      end
      if (!continuous_receive_enable) begin
        // Error clears while continuous receive is off
        overrun <= 1'b0;
      end else if (rx_done && !buf_free) begin
        // Unread word kept, new word dropped
        overrun <= 1'b1;
      end
    end
  end

endmodule

// File: logic/ssp_host.sv
`timescale 1ns/1ps
module ssp_host
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ssp_link_if.host link,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] dt_sync; // Data line synchroniser
  logic ack; // Bus answer cycle
  logic nine; // Nine bit words
  logic drive; // Master sends data this word
  logic [8:0] txd; // Word to send
  logic [8:0] rxd; // Last word received
  logic [8:0] tx_sh; // Outgoing bits
  logic [8:0] rx_sh; // Incoming bits
  logic busy; // Word in progress
  logic done; // Word finished
  logic sck; // Shift clock
  logic [3:0] ph; // Phase within one bit
  logic [3:0] bitn; // Bit index

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire access = (read | write) & ~ack;
  wire wr_done = write & ack;
  wire sel_ctrl = (address == HREG_CTRL);
  wire sel_txd = (address == HREG_TXD);
  wire sel_rxd = (address == HREG_RXD);
  wire go = wr_done & sel_ctrl & writedata[H_GO] & ~busy;
  wire [3:0] len = nine ? LEN9 : LEN8;
  wire fall_now = busy & (ph == HOST_HALF - 4'h1);
  wire bit_end = busy & (ph == {HOST_HALF[2:0], 1'b0} - 4'h1);
  wire [8:0] rx_in = {dt_sync[1], rx_sh[8:1]};
  wire [7:0] ctrl_rd = {3'b000, done, busy, drive, nine, 1'b0};
  wire [8:0] rd_val = sel_ctrl ? {1'b0, ctrl_rd} :
                      sel_txd ? txd :
                      sel_rxd ? rxd : 9'h000;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waitrequest = access;
  assign link.sck = sck;
  assign link.host_dt_oe = drive & busy;
  assign link.host_dt_out = tx_sh[0];

  // ----------------------------------------------------------------
  // Synchroniser and bus slave
  // ----------------------------------------------------------------
  // Data line passes two flops; answer one cycle after request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dt_sync <= 2'h3;
      ack <= 1'b0;
      readdata <= 32'h0;
    end else if (ce) begin
      dt_sync <= {dt_sync[0], link.dt};
      ack <= access;
      if (access && read) begin
        readdata <= {23'h0, rd_val};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Mode and data are ignored while a word runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nine <= 1'b0;
      drive <= 1'b0;
      txd <= 9'h000;
    end else if (ce && wr_done && !busy) begin
      if (sel_ctrl) begin
        nine <= writedata[H_NINE];
        drive <= writedata[H_DRIVE];
      end
      if (sel_txd) begin
        txd <= writedata[8:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Word engine: high half, falling edge sample, low half
  // ----------------------------------------------------------------
  // Own data changes at the end of the low half, as the clock rises again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      sck <= 1'b0;
      ph <= 4'h0;
      bitn <= 4'h0;
      tx_sh <= 9'h1ff;
      rx_sh <= 9'h000;
      rxd <= 9'h000;
    end else if (ce) begin
      if (go) begin
        busy <= 1'b1;
        done <= 1'b0;
        sck <= 1'b1;
        ph <= 4'h0;
        bitn <= 4'h0;
        tx_sh <= txd;
      end else if (busy) begin
        ph <= ph + 4'h1;
        if (fall_now) begin
          // Clock falls; take the device bit
          sck <= 1'b0;
          rx_sh <= rx_in;
        end
        if (bit_end && bitn == len - 4'h1) begin
          // Last bit ends the word
          busy <= 1'b0;
          done <= 1'b1;
          ph <= 4'h0;
          rxd <= nine ? rx_sh : {1'b0, rx_sh[8:1]};
        end else if (bit_end) begin
          // Next bit, clock rises again
          ph <= 4'h0;
          bitn <= bitn + 4'h1;
          tx_sh <= {1'b1, tx_sh[8:1]};
          sck <= 1'b1;
        end
      end
    end
  end

endmodule

// File: test/ssp_link_chk.sv
`timescale 1ns/1ps
module ssp_link_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic dev_dt_out,
  input wire logic dev_dt_oe,
  input wire logic host_dt_out,
  input wire logic host_dt_oe,
  input wire logic dt
);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic [4:0] low_run; // Cycles since sck was last high
  logic [3:0] rises; // Shift clock rises seen in this frame
  // Count low cycles and rises; a long low gap starts a new frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run <= 5'h0;
      rises <= 4'h0;
    end else begin
      low_run <= sck ? 5'h0 : low_run + {4'h0, low_run != 5'h1f};
      if (sck && low_run != 5'h0) begin
        rises <= (low_run > 5'h8) ? 4'h1 : rises + 4'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_high8; sck [*8]; endsequence
  sequence s_low8; !sck [*8]; endsequence
  property p_one_driver; !(dev_dt_oe && host_dt_oe); endproperty
  property p_sck_shape; $rose(sck) |-> s_high8 ##1 s_low8; endproperty
  property p_dev_hold; $fell(sck) && dev_dt_oe |-> $stable(dev_dt_out) [*2]; endproperty
  property p_host_hold; $rose(sck) && host_dt_oe |-> ##1 $stable(host_dt_out) [*7]; endproperty
  property p_dt_dev; dev_dt_oe |-> dt == dev_dt_out; endproperty
  property p_dt_host; host_dt_oe && !dev_dt_oe |-> dt == host_dt_out; endproperty
  property p_dt_idle; !dev_dt_oe && !host_dt_oe |-> dt; endproperty
  property p_frame_len; sck && low_run != 5'h0 && low_run <= 5'h8 |-> rises < 4'h9; endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
  a_sck_shape: assert property (p_sck_shape) else $error("shift clock shape wrong");
  a_dev_hold: assert property (p_dev_hold) else $error("device bit moved at sample");
  a_host_hold: assert property (p_host_hold) else $error("host bit moved in bit");
  a_dt_dev: assert property (p_dt_dev) else $error("line not device data");
  a_dt_host: assert property (p_dt_host) else $error("line not host data");
  a_dt_idle: assert property (p_dt_idle) else $error("idle line not high");
  a_frame_len: assert property (p_frame_len) else $error("too many bits in frame");
endmodule

// File: test/sync_serial_slave_port_tb.sv
`timescale 1ns/1ps
module sync_serial_slave_port_tb
  import ssp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, model and helpers
  // ----------------------------------------------------------------
  logic clk, rst_n, d_rd, d_wr, h_rd, h_wr, d_wait, h_wait, tx_irq, rx_irq;
  logic [4:0] d_ad, h_ad;
  logic [31:0] d_wd, h_wd, d_q, h_q, w;
  logic [31:0] rnd = 32'h60; // Xorshift state
  logic [31:0] rv [7] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h0}; // Reset reads
  logic [31:0] mq [$]; // Model queue of words in flight
  int mismatches = 0, total_checks = 0, cyc = 0;
  ssp_link_if lnk();
  ssp_device u_ssp_device(.clk(clk), .rst_n(rst_n), .ce(1'h1), .link(lnk.device), .address(d_ad),
    .read(d_rd), .write(d_wr), .writedata(d_wd), .readdata(d_q), .waitrequest(d_wait),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  ssp_host u_ssp_host(.clk(clk), .rst_n(rst_n), .ce(1'h1), .link(lnk.host), .address(h_ad),
    .read(h_rd), .write(h_wr), .writedata(h_wd), .readdata(h_q), .waitrequest(h_wait));
  ssp_link_chk u_ssp_link_chk(.clk(clk), .rst_n(rst_n), .sck(lnk.sck), .dev_dt_out(lnk.dev_dt_out),
    .dev_dt_oe(lnk.dev_dt_oe), .host_dt_out(lnk.host_dt_out), .host_dt_oe(lnk.host_dt_oe), .dt(lnk.dt));
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One Avalon transfer on either end, held until waitrequest is low
  task automatic bus(input bit h, input logic [4:0] a, input bit wn, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    if (h) begin
      h_ad <= a;
      h_rd <= !wn;
      h_wr <= wn;
      h_wd <= d;
    end else begin
      d_ad <= a;
      d_rd <= !wn;
      d_wr <= wn;
      d_wd <= d;
    end
    // Request held until waitrequest is seen low at a rising edge; only the hang guard ends a wait
    do begin
      @(posedge clk);
    end while ((h ? h_wait : d_wait) !== 1'h0);
    q = h ? h_q : d_q;
    {h_rd, h_wr, d_rd, d_wr} <= 4'h0;
  endtask
  task automatic wr(input bit h, input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(h, a, 1'h1, d, q);
  endtask
  task automatic rc(input bit h, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(h, a, 1'h0, 32'h0, q);
    chk(q, e);
  endtask
  // Read until a status bit is set; a bit that never sets runs into the hang guard
  task automatic poll(input bit h, input logic [4:0] a, input int b);
    logic [31:0] q;
    do begin
      bus(h, a, 1'h0, 32'h0, q);
    end while (q[b] !== 1'h1);
  endtask
  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, d_rd, d_wr, h_rd, h_wr} = 5'h0;
    {d_ad, h_ad, d_wd, h_wd} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 7; i++) rc(1'h0, 5'(i * 4), rv[i]);
    $display("test reset done");
    // Slave transmit, two words queued back to back
    wr(1'h0, REG_RX_CTRL, 32'h80);
    wr(1'h0, REG_TX_CTRL, 32'h30);
    wr(1'h0, REG_IRQ, 32'h1);
    // Enable lands at the write's closing edge; look once it has settled
    @(negedge clk);
    chk({31'h0, tx_irq}, 32'h1);
    for (int k = 0; k < 2; k++) begin
      w = xs();
      mq.push_back(w & 32'hff);
      wr(1'h0, REG_TX_HOLD, w);
      if (k == 0) rc(1'h0, REG_TX_CTRL, 32'h30);
    end
    rc(1'h0, REG_IRQ, 32'h1);
    chk({31'h0, tx_irq}, 32'h0);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        w = xs();
        mq.push_back(w & 32'h1ff);
        wr(1'h0, REG_TX_CTRL, 32'h70 | w[8]);
        wr(1'h0, REG_TX_HOLD, w);
      end
      wr(1'h1, HREG_CTRL, k == 2 ? 32'h3 : 32'h1);
      poll(1'h1, HREG_CTRL, H_DONE);
      rc(1'h1, HREG_RXD, mq.pop_front());
      rc(1'h0, REG_IRQ, 32'h11);
      chk({31'h0, tx_irq}, 32'h1);
    end
    $display("test transmit done");
    // Slave receive in 8 and 9 bit words, single enable set as well
    wr(1'h0, REG_TX_CTRL, 32'h10);
    wr(1'h0, REG_IRQ, 32'h2);
    for (int k = 0; k < 2; k++) begin
      w = xs() & (k ? 32'h1ff : 32'hff);
      mq.push_back(w);
      wr(1'h0, REG_RX_CTRL, k ? 32'hf0 : 32'hb0);
      wr(1'h1, HREG_TXD, w);
      wr(1'h1, HREG_CTRL, k ? 32'h7 : 32'h5);
      poll(1'h1, HREG_CTRL, H_DONE);
      poll(1'h0, REG_IRQ, IRQ_RECEIVE_COMPLETE_FLAG);
      chk({31'h0, rx_irq}, 32'h1);
      rc(1'h0, REG_RX_CTRL, (k ? 32'hf0 : 32'hb0) | w[8]);
      rc(1'h0, REG_RX_BUF, mq.pop_front() & 32'hff);
      // Holding register is empty, so the transmit empty flag reads set
      rc(1'h0, REG_IRQ, 32'h12);
    end
    $display("test receive done");
    // Overrun with the interrupt masked, then cleared by dropping receive
    wr(1'h0, REG_IRQ, 32'h0);
    wr(1'h0, REG_RX_CTRL, 32'hb0);
    for (int k = 0; k < 2; k++) begin
      w = xs() & 32'hff;
      mq.push_back(w);
      wr(1'h1, HREG_TXD, w);
      wr(1'h1, HREG_CTRL, 32'h5);
      poll(1'h1, HREG_CTRL, H_DONE);
    end
    rc(1'h0, REG_IRQ, 32'h30);
    chk({31'h0, rx_irq}, 32'h0);
    rc(1'h0, REG_RX_CTRL, 32'hb2);
    rc(1'h0, REG_RX_BUF, mq.pop_front());
    mq.delete();
    wr(1'h0, REG_RX_CTRL, 32'h80);
    rc(1'h0, REG_RX_CTRL, 32'h80);
    $display("test overrun done");
    report_and_stop();
  end
endmodule
